//--- core/csm_defines.svh
// Constants for the command source merge block
`ifndef CSM_DEFINES_SVH
`define CSM_DEFINES_SVH
`define CSM_POL_DIGITAL 2'h0
`define CSM_POL_SERIAL 2'h1
`define CSM_POL_AND 2'h2
`define CSM_POL_OR 2'h3
`define CSM_POL_DEFAULT 2'h3
`define CSM_PROF_PROFIDRIVE 2'h0
`define CSM_PROF_NATIVE 2'h1
`define CSM_PROF_FAST_IO 2'h2
`define CSM_PROF_DEFAULT 2'h1
`define CSM_SETUP_ONE 3'h1
`define CSM_JOG_W 16
`define CSM_JOG_DEFAULT 16'h0064
`define CSM_JOG_MIN 16'h0000
`define CSM_PRESET_W 2
`endif

//--- core/csm_pkg.sv
// Types for the command source merge block
package csm_pkg;
    typedef enum logic [1:0] {
        CSM_DIGITAL,
        CSM_SERIAL,
        CSM_AND,
        CSM_OR
    } csm_policy_t;
    typedef logic [1:0] csm_code_t;
endpackage : csm_pkg

//--- core/csm_merge_if.sv
// Interface carrying one merge request and its answer
`timescale 1ns/1ps
interface csm_merge_if;
    logic [1:0] policy;
    logic [1:0] digital;
    logic [1:0] serial;
    logic [1:0] merged;
    modport user (output policy, output digital, output serial, input merged);
    modport merger (input policy, input digital, input serial, output merged);
endinterface : csm_merge_if

//--- core/csm_source_merge.sv
// Four-policy combiner for a 2-bit command field
`timescale 1ns/1ps
`include "csm_defines.svh"
module csm_source_merge (
    csm_merge_if.merger mp
);
    always_comb begin
        if (mp.policy == `CSM_POL_DIGITAL) begin
            mp.merged = mp.digital;
        end else if (mp.policy == `CSM_POL_SERIAL) begin
            mp.merged = mp.serial;
        end else if (mp.policy == `CSM_POL_AND) begin
            mp.merged = mp.digital & mp.serial;
        end else begin
            mp.merged = mp.digital | mp.serial;
        end
    end
endmodule : csm_source_merge

//--- core/csm_command_merge.sv
// Merges terminal and serial drive commands under per-function policies
// Summary of operation
// - Start follows digital, serial, AND or OR of both per policy codes 0 to 3.
// - Anti-clockwise is chosen by the same four policies, clockwise otherwise.
// - Digital-only setup selection takes the two terminal setup bits alone.
// - Serial-only setup selection decodes bus bits 00..11 as setups 1..4.
// - AND setup selection ANDs both 2-bit codes and adds one.
// - OR setup selection ORs both 2-bit codes and adds one.
// - Preset reference selection uses the same combining with its own policy.
// - Serial preset selections count only while the profile is native code 1.
// - Bus jog activation over serial works only under profile code 0; speed selection is not gated.
// - Each bus jog speed is clamped to 0..high limit with reset default 10.0 Hz.
// - The profile encodes 0 Profidrive, 1 native (default), 2 fast I/O native.
// - Under serial-only policy a function follows its serial bits alone, preset only under native profile.
`timescale 1ns/1ps
`include "csm_defines.svh"
module csm_command_merge (
    input wire logic clk,
    input wire logic rst,
    input wire logic cfgWrite,
    input wire csm_pkg::csm_code_t startPolicyIn,
    input wire csm_pkg::csm_code_t reversePolicyIn,
    input wire csm_pkg::csm_code_t setupPolicyIn,
    input wire csm_pkg::csm_code_t presetPolicyIn,
    input wire csm_pkg::csm_code_t profileIn,
    input wire logic [`CSM_JOG_W-1:0] busJog1In,
    input wire logic [`CSM_JOG_W-1:0] busJog2In,
    input wire logic [`CSM_JOG_W-1:0] freqHighLimit,
    input wire logic digStart,
    input wire logic serStart,
    input wire logic digReverse,
    input wire logic serReverse,
    input wire logic [1:0] digSetup,
    input wire logic [1:0] serSetup,
    input wire logic [`CSM_PRESET_W-1:0] digPreset,
    input wire logic [`CSM_PRESET_W-1:0] serPreset,
    input wire logic serJogSelect,
    input wire logic serJogEnable,
    output logic startCmd,
    output logic antiClockwise,
    output logic [2:0] activeSetup,
    output logic [`CSM_PRESET_W-1:0] presetSel,
    output logic jogActive,
    output logic [`CSM_JOG_W-1:0] jogSpeed,
    output csm_pkg::csm_code_t profile,
    output logic [`CSM_JOG_W-1:0] busJog1,
    output logic [`CSM_JOG_W-1:0] busJog2
);
    import csm_pkg::*;

    // Configuration state
    csm_code_t startPol_reg, startPol_next;
    csm_code_t revPol_reg, revPol_next;
    csm_code_t setupPol_reg, setupPol_next;
    csm_code_t presetPol_reg, presetPol_next;
    csm_code_t profile_reg, profile_next;
    logic [`CSM_JOG_W-1:0] jog1_reg, jog1_next;
    logic [`CSM_JOG_W-1:0] jog2_reg, jog2_next;

    function automatic logic [`CSM_JOG_W-1:0] clampJog(
        input logic [`CSM_JOG_W-1:0] v,
        input logic [`CSM_JOG_W-1:0] hi
    );
        clampJog = (v > hi) ? hi : v;
    endfunction : clampJog

    always_comb begin
        startPol_next = startPol_reg;
        revPol_next = revPol_reg;
        setupPol_next = setupPol_reg;
        presetPol_next = presetPol_reg;
        profile_next = profile_reg;
        jog1_next = clampJog(jog1_reg, freqHighLimit);
        jog2_next = clampJog(jog2_reg, freqHighLimit);
        if (cfgWrite) begin
            startPol_next = startPolicyIn;
            revPol_next = reversePolicyIn;
            setupPol_next = setupPolicyIn;
            presetPol_next = presetPolicyIn;
            // Unknown profile code 3 is refused, keeping the old value
            if (profileIn <= `CSM_PROF_FAST_IO) begin
                profile_next = profileIn;
            end
            jog1_next = clampJog(busJog1In, freqHighLimit);
            jog2_next = clampJog(busJog2In, freqHighLimit);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            startPol_reg <= `CSM_POL_DEFAULT;
            revPol_reg <= `CSM_POL_DEFAULT;
            setupPol_reg <= `CSM_POL_DEFAULT;
            presetPol_reg <= `CSM_POL_DEFAULT;
            profile_reg <= `CSM_PROF_DEFAULT;
            jog1_reg <= `CSM_JOG_DEFAULT;
            jog2_reg <= `CSM_JOG_DEFAULT;
        end else begin
            startPol_reg <= startPol_next;
            revPol_reg <= revPol_next;
            setupPol_reg <= setupPol_next;
            presetPol_reg <= presetPol_next;
            profile_reg <= profile_next;
            jog1_reg <= jog1_next;
            jog2_reg <= jog2_next;
        end
    end

    // One combiner instance per function
    csm_merge_if mStart();
    csm_merge_if mRev();
    csm_merge_if mSetup();
    csm_merge_if mPreset();

    // Serial preset bits only count under the native profile
    logic [`CSM_PRESET_W-1:0] serPresetGated;
    assign serPresetGated = (profile_reg == `CSM_PROF_NATIVE) ? serPreset : '0;

    assign mStart.policy = startPol_reg;
    assign mStart.digital = {1'b0, digStart};
    assign mStart.serial = {1'b0, serStart};
    assign mRev.policy = revPol_reg;
    assign mRev.digital = {1'b0, digReverse};
    assign mRev.serial = {1'b0, serReverse};
    assign mSetup.policy = setupPol_reg;
    assign mSetup.digital = digSetup;
    assign mSetup.serial = serSetup;
    assign mPreset.policy = presetPol_reg;
    assign mPreset.digital = digPreset;
    assign mPreset.serial = serPresetGated;

    csm_source_merge uStart (.mp(mStart));
    csm_source_merge uRev (.mp(mRev));
    csm_source_merge uSetup (.mp(mSetup));
    csm_source_merge uPreset (.mp(mPreset));

    // Merged outputs
    logic start_reg, start_next;
    logic acw_reg, acw_next;
    logic [2:0] setup_reg, setup_next;
    logic [`CSM_PRESET_W-1:0] preset_reg, preset_next;
    logic jog_reg, jog_next;
    logic [`CSM_JOG_W-1:0] jogSpd_reg, jogSpd_next;

    always_comb begin
        start_next = mStart.merged[0];
        acw_next = mRev.merged[0];
        setup_next = {1'b0, mSetup.merged} + `CSM_SETUP_ONE;
        preset_next = mPreset.merged;
        // Jog over the bus is honoured only under Profidrive
        jog_next = serJogEnable && (profile_reg == `CSM_PROF_PROFIDRIVE);
        jogSpd_next = serJogSelect ? jog2_reg : jog1_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            start_reg <= 1'b0;
            acw_reg <= 1'b0;
            setup_reg <= `CSM_SETUP_ONE;
            preset_reg <= '0;
            jog_reg <= 1'b0;
            jogSpd_reg <= `CSM_JOG_DEFAULT;
        end else begin
            start_reg <= start_next;
            acw_reg <= acw_next;
            setup_reg <= setup_next;
            preset_reg <= preset_next;
            jog_reg <= jog_next;
            jogSpd_reg <= jogSpd_next;
        end
    end

    assign startCmd = start_reg;
    assign antiClockwise = acw_reg;
    assign activeSetup = setup_reg;
    assign presetSel = preset_reg;
    assign jogActive = jog_reg;
    assign jogSpeed = jogSpd_reg;
    assign profile = profile_reg;
    assign busJog1 = jog1_reg;
    assign busJog2 = jog2_reg;

    // Checks
    chk_start_policy: assert property (@(posedge clk) disable iff (rst)
        ##1 !$past(rst) |-> startCmd == ($past(startPol_reg) == `CSM_POL_DIGITAL ? $past(digStart)
        : $past(startPol_reg) == `CSM_POL_SERIAL ? $past(serStart)
        : $past(startPol_reg) == `CSM_POL_AND ? ($past(digStart) & $past(serStart))
        : ($past(digStart) | $past(serStart))))
        else $error("start merge wrong");
    chk_reverse_and: assert property (@(posedge clk) disable iff (rst)
        (revPol_reg == `CSM_POL_AND && !(digReverse && serReverse)) |=> !antiClockwise)
        else $error("reverse AND wrong");
    chk_setup_digital: assert property (@(posedge clk) disable iff (rst)
        setupPol_reg == `CSM_POL_DIGITAL |=>
        activeSetup == {1'b0, $past(digSetup)} + `CSM_SETUP_ONE)
        else $error("digital setup wrong");
    chk_setup_serial: assert property (@(posedge clk) disable iff (rst)
        setupPol_reg == `CSM_POL_SERIAL |=>
        activeSetup == {1'b0, $past(serSetup)} + `CSM_SETUP_ONE)
        else $error("serial setup wrong");
    chk_setup_and: assert property (@(posedge clk) disable iff (rst)
        setupPol_reg == `CSM_POL_AND |=>
        activeSetup == {1'b0, $past(serSetup) & $past(digSetup)} + `CSM_SETUP_ONE)
        else $error("AND setup wrong");
    chk_setup_or: assert property (@(posedge clk) disable iff (rst)
        setupPol_reg == `CSM_POL_OR |=>
        activeSetup == {1'b0, $past(serSetup) | $past(digSetup)} + `CSM_SETUP_ONE)
        else $error("OR setup wrong");
    chk_preset_gate: assert property (@(posedge clk) disable iff (rst)
        (profile_reg != `CSM_PROF_NATIVE && presetPol_reg == `CSM_POL_SERIAL) |=> presetSel == '0)
        else $error("preset not gated");
    chk_jog_profile: assert property (@(posedge clk) disable iff (rst)
        jogActive |-> $past(profile_reg) == `CSM_PROF_PROFIDRIVE)
        else $error("jog outside profile");
    chk_jog_bound: assert property (@(posedge clk) disable iff (rst)
        ##1 !$past(rst) && !$past(cfgWrite) |-> busJog1 <= $past(freqHighLimit))
        else $error("jog above limit");
    chk_reset_default: assert property (@(posedge clk)
        rst |=> profile == `CSM_PROF_NATIVE && startPol_reg == `CSM_POL_DEFAULT)
        else $error("reset default wrong");
    chk_profile_keep: assert property (@(posedge clk) disable iff (rst)
        (cfgWrite && profileIn > `CSM_PROF_FAST_IO) |=> profile == $past(profile))
        else $error("bad profile code taken");
    cov_start_and: cover property (@(posedge clk) startPol_reg == `CSM_POL_AND && startCmd);
    cov_setup_four: cover property (@(posedge clk) activeSetup == 3'h4);
    cov_jog: cover property (@(posedge clk) jogActive);
    cov_preset: cover property (@(posedge clk) presetSel != '0);
endmodule : csm_command_merge

//--- tb/csm_far_side.sv
// Far side model: bus master control word bits and terminal inputs
`timescale 1ns/1ps
module csm_far_side (
    input wire logic [13:0] word,
    output logic digStart,
    output logic serStart,
    output logic digReverse,
    output logic serReverse,
    output logic [1:0] digSetup,
    output logic [1:0] serSetup,
    output logic [1:0] digPreset,
    output logic [1:0] serPreset,
    output logic serJogSelect,
    output logic serJogEnable
);
    // Terminals and bus bits are fixed slices of one word, so the bench knows what was sent
    // Jog request is raised by the master in any profile; the block must gate it
    assign {serJogEnable, serJogSelect, serPreset, digPreset, serSetup, digSetup,
        serReverse, digReverse, serStart, digStart} = word;
endmodule : csm_far_side

//--- tb/csm_command_merge_test.sv
// Random self-checking bench for the command source merge block
`timescale 1ns/1ps
module csm_command_merge_test;
    import csm_pkg::*;
    logic clk;
    logic rst = 1;
    logic cfgWrite = 0;
    csm_code_t stP = 0, rvP = 0, suP = 0, prP = 0, pfIn = 0, profile;
    logic [15:0] j1In = 0, j2In = 0, lim = 0, jogSpeed, busJog1, busJog2;
    logic [13:0] word = 0;
    logic [31:0] r;
    logic dS, sS, dR, sR, sJs, sJe, startCmd, antiClockwise, jogActive;
    logic [1:0] dSu, sSu, dPr, sPr, presetSel;
    logic [2:0] activeSetup;
    int n_mismatch = 0, n_tests = 0;
    integer seed = 7241;
    int mPol[4], mProf, mJ1, mJ2, eSt, eRv, eSu, ePr, eJa, eJs;

    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end

    csm_far_side i_far (.word(word), .digStart(dS), .serStart(sS), .digReverse(dR),
        .serReverse(sR), .digSetup(dSu), .serSetup(sSu), .digPreset(dPr), .serPreset(sPr),
        .serJogSelect(sJs), .serJogEnable(sJe));

    csm_command_merge i_dut (.clk(clk), .rst(rst), .cfgWrite(cfgWrite), .startPolicyIn(stP),
        .reversePolicyIn(rvP), .setupPolicyIn(suP), .presetPolicyIn(prP), .profileIn(pfIn),
        .busJog1In(j1In), .busJog2In(j2In), .freqHighLimit(lim), .digStart(dS),
        .serStart(sS), .digReverse(dR), .serReverse(sR), .digSetup(dSu), .serSetup(sSu),
        .digPreset(dPr), .serPreset(sPr), .serJogSelect(sJs), .serJogEnable(sJe),
        .startCmd(startCmd), .antiClockwise(antiClockwise), .activeSetup(activeSetup),
        .presetSel(presetSel), .jogActive(jogActive), .jogSpeed(jogSpeed),
        .profile(profile), .busJog1(busJog1), .busJog2(busJog2));

    function automatic int mrg(input int pol, input int d, input int s);
        return (pol == 0) ? d : (pol == 1) ? s : (pol == 2) ? (d & s) : (d | s);
    endfunction : mrg

    task automatic chk(input logic [15:0] got, input int exp, input string what);
        n_tests++;
        if (got !== 16'(exp)) begin
            n_mismatch++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : chk

    // Raises reset just after an edge; defaults expected at the first edge after release
    task automatic do_reset(input int cyc);
        @(posedge clk);
        #1;
        rst = 1;
        word = 0;
        cfgWrite = 0;
        repeat (cyc) @(posedge clk);
        #1 rst = 0;
        mPol = '{3, 3, 3, 3};
        mProf = 1;
        // Reset speeds are pulled down at the first free edge if the limit sits below them
        mJ1 = (lim < 100) ? lim : 100;
        mJ2 = mJ1;
        {eSt, eRv, eSu, ePr, eJa} = {32'd0, 32'd0, 32'd1, 32'd0, 32'd0};
        eJs = 100;
    endtask : do_reset

    task automatic run(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            chk(startCmd, eSt, "start");
            chk(antiClockwise, eRv, "rotation");
            chk(activeSetup, eSu, "setup");
            chk(presetSel, ePr, "preset");
            chk(jogActive, eJa, "jog request");
            chk(jogSpeed, eJs, "jog speed");
            chk(busJog1, mJ1, "jog one");
            chk(busJog2, mJ2, "jog two");
            chk(profile, mProf, "profile");
            r = $random(seed);
            word = 14'($random(seed));
            cfgWrite = (r[1:0] == 2'h0);
            {stP, rvP, suP, prP, pfIn} = r[11:2];
            // Far side outputs settle only after this step, so decode the word itself
            eSt = mrg(mPol[0], word[0], word[1]);
            eRv = mrg(mPol[1], word[2], word[3]);
            eSu = mrg(mPol[2], word[5:4], word[7:6]) + 1;
            ePr = mrg(mPol[3], word[9:8], (mProf == 1) ? word[11:10] : 0);
            eJa = word[13] && (mProf == 0);
            eJs = word[12] ? mJ2 : mJ1;
            // Limit may drop between loads; stored speeds must follow it down
            if (r[13:12] == 2'h0) lim = 16'($random(seed));
            if (cfgWrite) begin
                {j1In, j2In} = {r[31:16], 16'($random(seed))};
                mPol = '{stP, rvP, suP, prP};
                if (pfIn != 2'h3) mProf = pfIn;
                mJ1 = j1In;
                mJ2 = j2In;
            end
            if (mJ1 > lim) mJ1 = lim;
            if (mJ2 > lim) mJ2 = lim;
        end
    endtask : run

    task automatic complete_run;
        $display("Counts: %0d mismatches in %0d tests", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        #50000;
        n_mismatch++;
        $display("BAD %0t run did not finish", $time);
        complete_run();
    end

    initial begin
        do_reset(20);
        run(1500);
        $display("Test random merge done");
        do_reset(2);
        run(1500);
        $display("Test merge after second reset done");
        complete_run();
    end
endmodule : csm_command_merge_test
